//--- inc/pmg_pkg.sv
package pmg_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PHY_ADDR  = 12'h138;
  localparam logic [ADDR_W-1:0] IDX_MGMT_DATA = 12'h139;
  localparam logic [ADDR_W-1:0] IDX_MGMT_CTRL = 12'h13B;
  localparam logic [ADDR_W-1:0] IDX_GPIO      = 12'h13D;
  localparam logic [ADDR_W-1:0] IDX_WAKE      = 12'h13E;
  localparam logic [ADDR_W-1:0] IDX_BMCR      = 12'h140;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT  = 12'h150;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK  = 12'h151;

  localparam logic [ADDR_W-1:0] ADDR_PHY_ADDR  = 12'(IDX_PHY_ADDR * 4);
  localparam logic [ADDR_W-1:0] ADDR_MGMT_DATA = 12'(IDX_MGMT_DATA * 4);
  localparam logic [ADDR_W-1:0] ADDR_MGMT_CTRL = 12'(IDX_MGMT_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_GPIO      = 12'(IDX_GPIO * 4);
  localparam logic [ADDR_W-1:0] ADDR_WAKE      = 12'(IDX_WAKE * 4);
  localparam logic [ADDR_W-1:0] ADDR_BMCR      = 12'(IDX_BMCR * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 12'(IDX_IRQ_STAT * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 12'(IDX_IRQ_MASK * 4);

  // Management access control fields
  localparam int CTRL_OWNER_BIT = 6;
  localparam int CTRL_DIR_BIT   = 5;
  localparam int CTRL_OFF_MSB   = 4;

  // General purpose register fields
  localparam int GP_HOMENET_BIT = 4;
  localparam int GP_VAL1_BIT    = 3;
  localparam int GP_DIR1_BIT    = 2;
  localparam int GP_VAL0_BIT    = 1;
  localparam int GP_DIR0_BIT    = 0;
  // Arbitrary build choice: external home-network PHY support absent
  localparam logic HOMENET_SUPPORT = 1'b0;

  // Wake enables: link change 6, magic frame 5, wake frames 4..0
  localparam int WAKE_W       = 7;
  localparam int WAKE_LINK    = 6;
  localparam int WAKE_MAGIC   = 5;
  localparam logic [WAKE_W-1:0] WAKE_RST = 7'h00;

  // Basic mode control fields
  localparam int BMCR_RESET_BIT   = 15;
  localparam int BMCR_SPEED_BIT   = 13;
  localparam int BMCR_ANE_BIT     = 12;
  localparam int BMCR_RESTART_BIT = 9;
  localparam int BMCR_DUPLEX_BIT  = 8;
  localparam logic BMCR_SPEED_RST  = 1'b0;
  localparam logic BMCR_ANE_RST    = 1'b0;
  localparam logic BMCR_DUPLEX_RST = 1'b0;

  // Interrupt status bits
  localparam int IRQ_W        = 3;
  localparam int IRQ_MGMT     = 0;
  localparam int IRQ_WAKE     = 1;
  localparam int IRQ_GPIO     = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // One management transaction towards the PHY
  typedef struct packed {
    logic        write;     // 1 write, 0 read
    logic [4:0]  phy_addr;  // PHY address
    logic [4:0]  reg_off;   // PHY register offset
    logic [15:0] wdata;     // Value to write
  } pmg_mgmt_req_t;

  // Mode bits driven towards the PHY
  typedef struct packed {
    logic speed100;
    logic autoneg_en;
    logic full_duplex;
  } pmg_mode_t;

endpackage

//--- rtl/pmg_sync.sv
`timescale 1ns/1ns
module pmg_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,  // Core clock
  input  wire logic         rst,    // Async reset, active high
  input  wire logic [W-1:0] async_in, // Pin levels
  output logic      [W-1:0] sync_out  // Filtered levels
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Three stages; only stage1 feeds stage2 to keep metastability contained
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once the later two stages agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sync_out <= '0;
    else
      for (int i = 0; i < W; i++)
        if (stage2[i] == stage3[i])
          sync_out[i] <= stage3[i];
  end

endmodule // pmg_sync

//--- rtl/pmg_mgmt_xfer.sv
`timescale 1ns/1ns
module pmg_mgmt_xfer
  import pmg_pkg::*;
(
  input  wire logic          clock,     // Core clock
  input  wire logic          rst,       // Async reset, active high
  input  wire logic          start,     // One-cycle start pulse
  input  pmg_pkg::pmg_mgmt_req_t req_in, // Request fields at start
  output logic               done,      // One-cycle completion pulse
  output logic [15:0]        rdata,     // Read result, valid with done
  output logic               phy_valid, // Request held towards PHY side
  output pmg_pkg::pmg_mgmt_req_t phy_req, // Captured request
  input  wire logic          phy_ack,   // Serial framing finished
  input  wire logic [15:0]   phy_rdata  // Data returned by PHY
);

  typedef enum logic [0:0] {XF_IDLE, XF_WAIT} pmg_xf_state_t;
  pmg_xf_state_t state;

  // Request is latched so software edits cannot disturb a frame in flight
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state   <= XF_IDLE;
      phy_req <= '0;
    end
    else
      case (state)
        XF_IDLE:
          if (start)
          begin
            phy_req <= req_in;
            state   <= XF_WAIT;
          end
        XF_WAIT:
          if (phy_ack)
            state <= XF_IDLE;
        default:
          state <= XF_IDLE;
      endcase
  end

  assign phy_valid = (state == XF_WAIT);

  // Completion pulse and read capture
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      done  <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      done <= (state == XF_WAIT) && phy_ack;
      if ((state == XF_WAIT) && phy_ack && !phy_req.write)
        rdata <= phy_rdata;
    end
  end

endmodule // pmg_mgmt_xfer

//--- rtl/pmg_regs.sv
// Functional notes
// - Owner bit starts transaction, clears when done
// - Direction bit picks write/read; offset picks register
// - PHY address field bits 4-0, rest reserved
// - Data register sends writes, captures reads
// - Output pins follow data; inputs feed data
// - Direction bit one means output
// - Bit 4 reads home-network PHY support
// - Separate wake enables, all reset zero
// - Wake only when armed and enabled event
// - PHY reset bit restores defaults, self-clears
// - Speed bit: one 100, zero 10; config-loaded
// - Autoneg enable, reset zero, config-loaded
// - Autoneg on: speed/duplex writes ignored, show result
// - Restart bit relaunches negotiation
// - Duplex bit: one full; config-loaded
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module pmg_regs
  import pmg_pkg::*;
(
  input  wire logic        clock,           // Core clock, 100 MHz
  input  wire logic        rst,             // Async reset, active high
  input  wire logic [11:0] paddr,           // APB address
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error on unmapped address
  output logic             phy_valid,       // Management request pending
  output pmg_pkg::pmg_mgmt_req_t phy_req,   // Management request fields
  input  wire logic        phy_ack,         // Management frame finished
  input  wire logic [15:0] phy_rdata,       // Management read data
  input  wire logic [1:0]  gpio_in,         // General purpose pin levels
  output logic      [1:0]  gpio_out,        // General purpose pin drive
  output logic      [1:0]  gpio_oe,         // High while pin is driven
  input  wire logic        cfg_load,        // Pulse: config values valid
  input  wire logic        cfg_speed100,    // Config speed default
  input  wire logic        cfg_autoneg,     // Config autoneg default
  input  wire logic        cfg_full_duplex, // Config duplex default
  input  wire logic        an_speed100,     // Negotiated speed
  input  wire logic        an_full_duplex,  // Negotiated duplex
  output pmg_pkg::pmg_mode_t phy_mode,      // Effective mode towards PHY
  output logic             phy_soft_reset,  // Pulse: PHY register reset
  output logic             autoneg_restart, // Pulse: relaunch negotiation
  input  wire logic        remote_wake_armed, // Host enabled remote wakeup
  input  wire logic        link_change_evt, // Pulse: link changed
  input  wire logic        magic_frame_evt, // Pulse: magic frame seen
  input  wire logic [4:0]  wake_frame_evt,  // Pulses: wake frames 4..0
  output logic             remote_wake,     // Pulse: signal wakeup to host
  output logic             irq              // Level interrupt
);

  // Known-address decode, shared by read and write paths
  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      ADDR_PHY_ADDR, ADDR_MGMT_DATA, ADDR_MGMT_CTRL, ADDR_GPIO,
      ADDR_WAKE, ADDR_BMCR, ADDR_IRQ_STAT, ADDR_IRQ_MASK: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  logic [4:0]        phy_addr_field;
  logic [15:0]       mgmt_data_word;
  logic              access_owner_flag;
  logic              xfer_direction;
  logic [4:0]        phy_reg_offset;
  logic              gpio0_dir;
  logic              gpio1_dir;
  logic              gpio0_value;
  logic              gpio1_value;
  logic [WAKE_W-1:0] wake_en;
  logic              spd_sel;
  logic              autoneg_enable;
  logic              duplex_sel;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [1:0]        gpio_sync;
  logic [1:0]        gpio_sync_d;
  logic [1:0]        gpio_rd;
  logic              wr_acc;
  logic              rd_setup;
  logic              xfer_start;
  logic              xfer_done;
  logic [15:0]       xfer_rdata;
  logic              wake_hit;
  logic [IRQ_W-1:0]  irq_evt;
  logic [31:0]       next_prdata;
  pmg_mgmt_req_t     req_now;

  // Zero wait states: the access phase always completes at once
  assign pready   = penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  pmg_sync #(.W(2)) u_gpio_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (gpio_in),
    .sync_out (gpio_sync)
  );

  // New transaction only while idle; writes while busy cannot restart it
  assign xfer_start = wr_acc && (paddr == ADDR_MGMT_CTRL) && !access_owner_flag
                      && pwdata[CTRL_OWNER_BIT];
  assign req_now.write    = pwdata[CTRL_DIR_BIT];
  assign req_now.reg_off  = pwdata[CTRL_OFF_MSB:0];
  assign req_now.phy_addr = phy_addr_field;
  assign req_now.wdata    = mgmt_data_word;

  pmg_mgmt_xfer u_xfer (
    .clock     (clock),
    .rst       (rst),
    .start     (xfer_start),
    .req_in    (req_now),
    .done      (xfer_done),
    .rdata     (xfer_rdata),
    .phy_valid (phy_valid),
    .phy_req   (phy_req),
    .phy_ack   (phy_ack),
    .phy_rdata (phy_rdata)
  );

  // PHY address register; reserved bits are not stored
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      phy_addr_field <= '0;
    else if (wr_acc && paddr == ADDR_PHY_ADDR)
      phy_addr_field <= pwdata[4:0];
  end

  // Data word: read completion wins over a concurrent software write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mgmt_data_word <= '0;
    else if (xfer_done && !phy_req.write)
      mgmt_data_word <= xfer_rdata;
    else if (wr_acc && paddr == ADDR_MGMT_DATA)
      mgmt_data_word <= pwdata[15:0];
  end

  // Access control; fields are frozen while the owner bit is set
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      access_owner_flag <= 1'b0;
      xfer_direction    <= 1'b0;
      phy_reg_offset    <= '0;
    end
    else if (xfer_done)
      access_owner_flag <= 1'b0;
    else if (wr_acc && paddr == ADDR_MGMT_CTRL && !access_owner_flag)
    begin
      access_owner_flag <= pwdata[CTRL_OWNER_BIT];
      xfer_direction    <= pwdata[CTRL_DIR_BIT];
      phy_reg_offset    <= pwdata[CTRL_OFF_MSB:0];
    end
  end

  // GPIO: data bit stored only when the written direction is output
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gpio0_dir   <= 1'b0;
      gpio1_dir   <= 1'b0;
      gpio0_value <= 1'b0;
      gpio1_value <= 1'b0;
    end
    else if (wr_acc && paddr == ADDR_GPIO)
    begin
      gpio0_dir <= pwdata[GP_DIR0_BIT];
      gpio1_dir <= pwdata[GP_DIR1_BIT];
      if (pwdata[GP_DIR0_BIT])
        gpio0_value <= pwdata[GP_VAL0_BIT];
      if (pwdata[GP_DIR1_BIT])
        gpio1_value <= pwdata[GP_VAL1_BIT];
    end
  end

  // Drive pins from flip-flops; inputs read back their synchronised level
  assign gpio_oe  = {gpio1_dir, gpio0_dir};
  assign gpio_out = {gpio1_value, gpio0_value};
  assign gpio_rd  = {gpio1_dir ? gpio1_value : gpio_sync[1],
                     gpio0_dir ? gpio0_value : gpio_sync[0]};

  // Wake enables
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_en <= WAKE_RST;
    else if (wr_acc && paddr == ADDR_WAKE)
      wake_en <= pwdata[WAKE_W-1:0];
  end

  // Wakeup needs both the host's arming and an enabled, triggered source
  assign wake_hit = remote_wake_armed
                    && |(wake_en & {link_change_evt, magic_frame_evt, wake_frame_evt});

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      remote_wake <= 1'b0;
    else
      remote_wake <= wake_hit;
  end

  // Mode bits; PHY reset and config load reapply the defaults
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      spd_sel        <= BMCR_SPEED_RST;
      autoneg_enable <= BMCR_ANE_RST;
      duplex_sel     <= BMCR_DUPLEX_RST;
    end
    else if (cfg_load || (wr_acc && paddr == ADDR_BMCR && pwdata[BMCR_RESET_BIT]))
    begin
      spd_sel        <= cfg_speed100;
      autoneg_enable <= cfg_autoneg;
      duplex_sel     <= cfg_full_duplex;
    end
    else if (wr_acc && paddr == ADDR_BMCR)
    begin
      autoneg_enable <= pwdata[BMCR_ANE_BIT];
      // Ignored while negotiation runs, judged before this write's own change
      if (!autoneg_enable)
      begin
        spd_sel    <= pwdata[BMCR_SPEED_BIT];
        duplex_sel <= pwdata[BMCR_DUPLEX_BIT];
      end
    end
  end

  // Reset and restart are strobes, so both read back as zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      phy_soft_reset  <= 1'b0;
      autoneg_restart <= 1'b0;
    end
    else
    begin
      phy_soft_reset  <= wr_acc && paddr == ADDR_BMCR && pwdata[BMCR_RESET_BIT];
      autoneg_restart <= wr_acc && paddr == ADDR_BMCR && pwdata[BMCR_RESTART_BIT]
                         && !pwdata[BMCR_RESET_BIT];
    end
  end

  // With negotiation on, report its outcome instead of the stored choice
  assign phy_mode.autoneg_en  = autoneg_enable;
  assign phy_mode.speed100    = autoneg_enable ? an_speed100 : spd_sel;
  assign phy_mode.full_duplex = autoneg_enable ? an_full_duplex : duplex_sel;

  // Input-pin edge detect on the filtered level only
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gpio_sync_d <= '0;
    else
      gpio_sync_d <= gpio_sync;
  end

  assign irq_evt[IRQ_MGMT] = xfer_done;
  assign irq_evt[IRQ_WAKE] = wake_hit;
  assign irq_evt[IRQ_GPIO] = |((gpio_sync ^ gpio_sync_d) & ~{gpio1_dir, gpio0_dir});

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_stat <= IRQ_RST;
    else if (wr_acc && paddr == ADDR_IRQ_STAT)
      irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat <= irq_stat | irq_evt;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_mask <= IRQ_RST;
    else if (wr_acc && paddr == ADDR_IRQ_MASK)
      irq_mask <= pwdata[IRQ_W-1:0];
  end

  assign irq = |(irq_stat & irq_mask);

  // Read mux; reserved bits read as zero
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_PHY_ADDR:  next_prdata = {27'h0, phy_addr_field};
      ADDR_MGMT_DATA: next_prdata = {16'h0, mgmt_data_word};
      ADDR_MGMT_CTRL: next_prdata = {25'h0, access_owner_flag, xfer_direction, phy_reg_offset};
      ADDR_GPIO:      next_prdata = {27'h0, HOMENET_SUPPORT, gpio_rd[1], gpio1_dir,
                                     gpio_rd[0], gpio0_dir};
      ADDR_WAKE:      next_prdata = {25'h0, wake_en};
      ADDR_BMCR:      next_prdata = {18'h0, phy_mode.speed100, autoneg_enable, 3'h0,
                                     phy_mode.full_duplex, 8'h00};
      ADDR_IRQ_STAT:  next_prdata = {29'h0, irq_stat};
      ADDR_IRQ_MASK:  next_prdata = {29'h0, irq_mask};
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data and error are registered in the setup cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_setup || (psel && !penable))
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !addr_known(paddr);
    end
    else if (!psel)
      pslverr <= 1'b0;
  end

endmodule // pmg_regs

//--- tb/pmg_properties.sv
`timescale 1ns/1ns
module pmg_properties
  import pmg_pkg::*;
(
  input wire logic               clock,           // Core clock
  input wire logic               rst,             // Async reset
  input wire logic [11:0]        paddr,           // APB address
  input wire logic               psel,            // APB select
  input wire logic               penable,         // APB enable
  input wire logic               pwrite,          // APB direction
  input wire logic [31:0]        pwdata,          // APB write data
  input wire logic               pready,          // APB ready
  input wire logic               phy_valid,       // Request pending
  input pmg_pkg::pmg_mgmt_req_t  phy_req,         // Request fields
  input wire logic               phy_ack,         // Frame finished
  input wire logic [1:0]         gpio_out,        // Pin drive
  input wire logic [1:0]         gpio_oe,         // Pin enable
  input wire logic               cfg_load,        // Config strobe
  input wire logic               an_speed100,     // Negotiated speed
  input wire logic               an_full_duplex,  // Negotiated duplex
  input pmg_pkg::pmg_mode_t      phy_mode,        // Effective mode
  input wire logic               phy_soft_reset,  // Reset strobe
  input wire logic               autoneg_restart, // Restart strobe
  input wire logic               remote_wake_armed, // Host armed
  input wire logic               remote_wake      // Wake strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Completed writes, decoded per register
  wire acc  = psel && penable && pwrite && pready;
  wire go   = acc && paddr == ADDR_MGMT_CTRL && pwdata[6] && !phy_valid;
  wire bmcr = acc && paddr == ADDR_BMCR && !cfg_load;
  wire gpw  = acc && paddr == ADDR_GPIO;

  a_start_raises_valid: assert property (go |=> phy_valid)
    else $error("start did not raise request");
  a_req_fields_latched: assert property (go |=> phy_req.write == $past(pwdata[5])
    && phy_req.reg_off == $past(pwdata[4:0])) else $error("request fields wrong");
  a_req_held_stable: assert property (phy_valid && !phy_ack |=> phy_valid && $stable(phy_req))
    else $error("request changed before ack");
  a_ack_ends_valid: assert property (phy_valid && phy_ack |=> !phy_valid)
    else $error("request outlived ack");
  a_dir_drives_oe: assert property (gpw |=> gpio_oe == {$past(pwdata[2]), $past(pwdata[0])})
    else $error("pin enable wrong");
  a_pin_follows_data: assert property (gpw && pwdata[2] |=> gpio_out[1] == $past(pwdata[3]))
    else $error("pin drive wrong");
  a_wake_needs_arm: assert property (remote_wake |-> $past(remote_wake_armed))
    else $error("wake without arming");
  a_soft_reset_pulse: assert property (bmcr && pwdata[15] |=> phy_soft_reset ##1 !phy_soft_reset)
    else $error("soft reset strobe wrong");
  a_restart_pulse: assert property (bmcr && pwdata[9] && !pwdata[15]
    |=> autoneg_restart ##1 !autoneg_restart) else $error("restart strobe wrong");
  a_autoneg_result: assert property (phy_mode.autoneg_en |-> phy_mode.speed100 == an_speed100
    && phy_mode.full_duplex == an_full_duplex) else $error("mode ignores negotiation");
  a_speed_written: assert property (bmcr && !pwdata[15] && !pwdata[12] && !phy_mode.autoneg_en
    |=> phy_mode.speed100 == $past(pwdata[13]) && phy_mode.full_duplex == $past(pwdata[8]))
    else $error("manual mode not taken");

  // Main scenarios reached
  c_mgmt_done: cover property (phy_valid && phy_ack);
  c_wake: cover property (remote_wake);
  c_soft_reset: cover property (phy_soft_reset);
endmodule // pmg_properties

bind pmg_regs pmg_properties u_props (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .phy_valid, .phy_req, .phy_ack, .gpio_out, .gpio_oe, .cfg_load, .an_speed100, .an_full_duplex,
  .phy_mode, .phy_soft_reset, .autoneg_restart, .remote_wake_armed, .remote_wake);

//--- tb/pmg_phy_model.sv
`timescale 1ns/1ns
module pmg_phy_model
  import pmg_pkg::*;
(
  input wire logic              clock,     // Core clock
  input wire logic              rst,       // Async reset
  input wire logic              slow,      // Stretch the answer
  input wire logic              phy_valid, // Request pending
  input pmg_pkg::pmg_mgmt_req_t phy_req,   // Request fields
  output logic                  phy_ack,   // Frame finished
  output logic [15:0]           phy_rdata  // Returned data
);
  logic [15:0] mem [0:1023];
  logic [2:0]  cnt;

  // Register contents before any write
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'(i ^ 'hA5C3);

  // Answer after one or five cycles; data toggles outside the answer
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 3'h0;
      phy_ack <= 1'b0;
      phy_rdata <= 16'h0000;
    end
    else
    begin
      phy_ack <= 1'b0;
      phy_rdata <= ~phy_rdata;
      if (phy_valid && !phy_ack)
      begin
        cnt <= cnt + 3'h1;
        if (cnt >= (slow ? 3'h4 : 3'h0))
        begin
          cnt <= 3'h0;
          phy_ack <= 1'b1;
          phy_rdata <= mem[{phy_req.phy_addr, phy_req.reg_off}];
          if (phy_req.write) mem[{phy_req.phy_addr, phy_req.reg_off}] <= phy_req.wdata;
        end
      end
    end
  end
endmodule // pmg_phy_model

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  import pmg_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, r, v;
  logic          psel, penable, pwrite, pready, pslverr, phy_valid, phy_ack, e, dir;
  logic          cfg_load, cfg_speed100, cfg_autoneg, cfg_full_duplex, an_speed100, an_full_duplex;
  logic          phy_soft_reset, autoneg_restart, remote_wake_armed, remote_wake, irq, slow;
  logic [1:0]    gpio_in, gpio_out, gpio_oe;
  logic [4:0]    a, o;
  logic [6:0]    wake_evt;
  logic [15:0]   phy_rdata;
  pmg_mgmt_req_t phy_req;
  pmg_mode_t     phy_mode;
  int            n_mismatch = 0;
  int            num_checks = 0;
  int            seed = 8;
  int            n;
  int            bmem [1024];
  logic [11:0]   ra [8] = '{ADDR_PHY_ADDR, ADDR_MGMT_DATA, ADDR_MGMT_CTRL, ADDR_GPIO, ADDR_WAKE,
                            ADDR_BMCR, ADDR_IRQ_STAT, ADDR_IRQ_MASK};

  // 100 MHz core clock
  always #5 clock = ~clock;

  pmg_regs uut (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .phy_valid, .phy_req, .phy_ack, .phy_rdata, .gpio_in, .gpio_out, .gpio_oe, .cfg_load, .cfg_speed100,
    .cfg_autoneg, .cfg_full_duplex, .an_speed100, .an_full_duplex, .phy_mode, .phy_soft_reset,
    .autoneg_restart, .remote_wake_armed, .link_change_evt(wake_evt[6]), .magic_frame_evt(wake_evt[5]),
    .wake_frame_evt(wake_evt[4:0]), .remote_wake, .irq);

  pmg_phy_model phy (.clock, .rst, .slow, .phy_valid, .phy_req, .phy_ack, .phy_rdata);

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high or 50 cycles pass
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, r, e);
  endtask

  task automatic rc(input logic [11:0] ad, input logic [31:0] x, input string nm);
    apb(1'b0, ad, 32'h0, r, e);
    chk(nm, x, r);
  endtask

  // Pulse one wake source; strobe follows a cycle later
  task automatic wk(input int i, input logic arm, input logic x);
    @(posedge clock);
    remote_wake_armed <= arm;
    wake_evt <= 7'(1 << i);
    @(posedge clock);
    wake_evt <= 7'h00;
    #1 chk("remote_wake", {31'h0, x}, {31'h0, remote_wake});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    {psel, penable, pwrite, cfg_load, cfg_autoneg, remote_wake_armed, slow, an_full_duplex} = '0;
    {paddr, pwdata, gpio_in, wake_evt} = '0;
    {cfg_speed100, cfg_full_duplex, an_speed100} = 3'b111;
    for (int i = 0; i < 1024; i++) bmem[i] = i ^ 'hA5C3;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    foreach (ra[i]) rc(ra[i], (i == 3) ? 32'(HOMENET_SUPPORT) << 4 : 32'h0, "reset");
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    v = $random(seed);
    wr(ADDR_PHY_ADDR, v);
    rc(ADDR_PHY_ADDR, v & 32'h1F, "phy_addr");
    wr(ADDR_WAKE, v);
    rc(ADDR_WAKE, v & 32'h7F, "wake_en");
    $display("test registers done");
    // Read, write, read back; fast and slow answers
    for (int k = 0; k < 9; k++)
    begin
      if (k % 3 == 0)
      begin
        a = 5'($random(seed));
        o = 5'($random(seed));
      end
      v = $random(seed);
      dir = (k % 3 == 1);
      slow <= k[0];
      wr(ADDR_PHY_ADDR, {27'h0, a});
      wr(ADDR_MGMT_DATA, v);
      if (dir) bmem[{a, o}] = int'(v[15:0]);
      wr(ADDR_MGMT_CTRL, {25'h0, 1'b1, dir, o});
      if (k == 3) wr(ADDR_MGMT_CTRL, {25'h0, 2'b11, ~o});
      n = 0;
      do apb(1'b0, ADDR_MGMT_CTRL, 32'h0, r, e); while (r[6] && ++n < 40);
      chk("mgmt_ctrl", {25'h0, 1'b0, dir, o}, r);
      rc(ADDR_MGMT_DATA, 32'(bmem[{a, o}]), "mgmt_data");
    end
    $display("test management done");
    v = $random(seed);
    wr(ADDR_GPIO, v | 32'h5);
    #1 chk("gpio_out", {30'h0, v[3], v[1]}, {30'h0, gpio_out});
    chk("gpio_oe", 32'h3, {30'h0, gpio_oe});
    rc(ADDR_GPIO, {27'h0, HOMENET_SUPPORT, v[3], 1'b1, v[1], 1'b1}, "gpio_rd");
    wr(ADDR_GPIO, 32'h0A);
    gpio_in <= 2'b10;
    repeat (6) @(posedge clock);
    rc(ADDR_GPIO, {27'h0, HOMENET_SUPPORT, 4'b1000}, "gpio_pin");
    #1 chk("gpio_oe", 32'h0, {30'h0, gpio_oe});
    $display("test gpio done");
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_WAKE, 32'(1 << i));
      wk(i, 1'b1, 1'b1);
      wk((i + 1) % 7, 1'b1, 1'b0);
      wk(i, 1'b0, 1'b0);
    end
    $display("test wake done");
    rc(ADDR_IRQ_STAT, 32'h7, "irq_stat");
    wr(ADDR_IRQ_MASK, 32'h2);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h2);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rc(ADDR_IRQ_STAT, 32'h5, "irq_stat");
    $display("test interrupt done");
    @(posedge clock);
    {cfg_load, cfg_autoneg} <= 2'b11;
    @(posedge clock);
    {cfg_load, cfg_autoneg} <= 2'b00;
    rc(ADDR_BMCR, 32'h3000, "bmcr_cfg");
    wr(ADDR_BMCR, 32'h0);
    rc(ADDR_BMCR, 32'h2100, "bmcr_keep");
    wr(ADDR_BMCR, 32'h0);
    rc(ADDR_BMCR, 32'h0, "bmcr_man");
    wr(ADDR_BMCR, 32'h1000);
    rc(ADDR_BMCR, 32'h3000, "bmcr_an");
    an_full_duplex <= 1'b1;
    wr(ADDR_BMCR, 32'h1200);
    rc(ADDR_BMCR, 32'h3100, "bmcr_restart");
    #1 chk("phy_mode", 32'h7, {29'h0, phy_mode});
    wr(ADDR_BMCR, 32'h8000);
    rc(ADDR_BMCR, 32'h2100, "bmcr_reset");
    #1 chk("phy_mode", 32'h5, {29'h0, phy_mode});
    $display("test basic mode done");
    finish_test();
  end
endmodule // tb
